// >>> core/emb_pkg.sv
// Constants and types for the external memory bus control block.
// Assumes a single 100 MHz machine clock and a synchronous active-high reset.
//
// Overview of operation
// R1 - Space selects idle high, only one drives low
// R2 - Select low exactly while its address valid
// R3 - Selects float in hold or emulation float
// R4 - Memory strobe low only for data/program access
// R5 - Memory strobe floats during hold
// R6 - Memory strobe floats when emulation float low
// R7 - Ready low stretches access one cycle each
// R8 - Ready checked only with two+ software waits
// R9 - Ready ignored until software waits elapse
// R10 - Map select low: ROM in top 4K
// R11 - Map select high: ROM out of map
// R12 - Map select sampled only during reset
// R13 - Software mode bit write overrides reset mode
// R14 - Read-not-write low only on writes, floats
// R15 - I/O strobe low only for I/O access
// R16 - Hold request floats bus, raises acknowledge
// R17 - Never more than one space select low
`default_nettype none

package emb_pkg;

    // ************************************************************
    // Widths and encodings
    // ************************************************************
    localparam int EMB_ADDR_W = 20;                 // External address width
    localparam int EMB_WS_W = 3;                    // Software wait-state count width
    localparam logic [1:0] EMB_SPACE_DATA = 2'h0;   // Data space access
    localparam logic [1:0] EMB_SPACE_PROG = 2'h1;   // Program space access
    localparam logic [1:0] EMB_SPACE_IO = 2'h2;     // I/O space access
    localparam logic [2:0] EMB_READY_MIN_WS = 3'h2; // Least waits that enable ready check
    localparam logic [3:0] EMB_ROM_PAGE = 4'hf;     // Top 4K words of a 64K page
    localparam int EMB_ROM_LSB = 12;                // Lowest address bit of the ROM page
    localparam logic EMB_MODE_MICROCOMPUTER = 1'b0; // On-chip ROM mapped
    localparam logic EMB_MODE_MICROPROCESSOR = 1'b1; // On-chip ROM left out

    // ************************************************************
    // Types
    // ************************************************************
    // Main sequencer states, gray along idle -> access and idle -> hold
    typedef enum logic [1:0] {
        EMB_IDLE = 2'h0,
        EMB_ACCESS = 2'h1,
        EMB_HOLD = 2'h2
    } emb_fsm_type;

    // One access request from the core
    typedef struct packed {
        logic valid;                      // Request present this cycle
        logic [1:0] space;                // Target space
        logic write;                      // High for a write
        logic [EMB_ADDR_W-1:0] addr;      // Word address
        logic [EMB_WS_W-1:0] wait_states; // Programmed software waits
    } emb_req_type;

    // External control and address pins
    typedef struct packed {
        logic data_space_sel_n;
        logic program_space_sel_n;
        logic io_space_sel_n;
        logic memory_strobe_n;
        logic io_strobe_n;
        logic read_not_write;
        logic [EMB_ADDR_W-1:0] addr;
    } emb_pins_type;

    // Pin levels while the bus is idle
    localparam emb_pins_type EMB_PINS_IDLE = '{
        data_space_sel_n: 1'b1, program_space_sel_n: 1'b1, io_space_sel_n: 1'b1,
        memory_strobe_n: 1'b1, io_strobe_n: 1'b1, read_not_write: 1'b1,
        addr: '0};

    // Wait-state counter state
    typedef struct packed {
        logic [EMB_WS_W-1:0] count; // Software waits still to run
        logic check_ready;          // Ready detection enabled for this access
    } emb_wait_state_type;

    // Main block state
    typedef struct packed {
        emb_fsm_type fsm;
        emb_pins_type pins;
        logic pins_oe_n;     // Low while the pins are driven
        logic release_ack;   // Bus released to an outside master
        logic ack_oe_n;      // Low while the acknowledge is driven
        logic mode;          // Current ROM mapping mode
        logic done;          // One-cycle completion pulse
        logic rom_hit;       // Completed access went to on-chip ROM
        logic busy;          // Sequencer not idle
    } emb_state_type;

    // True when a program access falls on the on-chip ROM page
    function automatic logic emb_rom_hit(input logic mode, input emb_req_type req);
        return (mode == EMB_MODE_MICROCOMPUTER) && (req.space == EMB_SPACE_PROG) &&
            (req.addr[EMB_ROM_LSB+3:EMB_ROM_LSB] == EMB_ROM_PAGE);
    endfunction

endpackage : emb_pkg

`default_nettype wire

// >>> core/emb_wait.sv
// Software wait-state counter with ready extension.
// Assumes the main sequencer pulses i_start on the cycle it takes an access.
`default_nettype none

module emb_wait (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [emb_pkg::EMB_WS_W-1:0] i_wait_states,
    input wire logic i_ready,
    output logic o_last,
    output logic o_waiting,
    output logic o_checking
);
    import emb_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    emb_wait_state_type cur; // Registered state
    emb_wait_state_type next_cur; // Next state

    // Load on start, then count the software waits down
    always_comb begin
        next_cur = cur;
        if (i_start) begin
            next_cur.count = i_wait_states;
            next_cur.check_ready = (i_wait_states >= EMB_READY_MIN_WS); // R8
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - 1'b1;
        end
    end

    // Register the state
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Ready is looked at only once the count is spent
    assign o_last = (cur.count == '0) && (!cur.check_ready || i_ready); // R7 R9
    assign o_waiting = (cur.count != '0);
    assign o_checking = cur.check_ready;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    ws_no_early_a: assert property (i_start && (i_wait_states != '0) |=> !o_last) // R9
        else $error("access ended before software waits elapsed");
    ws_count_down_a: assert property ( // R9
        !i_start && o_waiting |=> cur.count == $past(cur.count) - 3'h1)
        else $error("software wait count did not step down");

endmodule // emb_wait

`default_nettype wire

// >>> core/emb_ctl.sv
// External memory bus control: space selects, strobes, hold and ROM mapping.
// Assumes requests come from the core in the machine clock domain and
// that the far side pin buffers resolve the output enables (low = drive).
`default_nettype none

module emb_ctl (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire emb_pkg::emb_req_type i_req,
    input wire logic i_ready,
    input wire logic i_hold_n,
    input wire logic i_emulation_float_n,
    input wire logic i_boot_map_select,
    input wire logic i_mode_wr,
    input wire logic i_mode_wdata,
    output emb_pkg::emb_pins_type o_pins,
    output logic o_pins_oe_n,
    output logic o_bus_release_ack,
    output logic o_bus_release_ack_oe_n,
    output logic o_processor_mode,
    output logic o_done,
    output logic o_rom_hit,
    output logic o_busy
);
    import emb_pkg::*;

    // ************************************************************
    // State and wait counter
    // ************************************************************
    emb_state_type cur; // Registered state
    emb_state_type next_cur; // Next state
    logic start; // Access taken to the external bus
    logic wait_last; // Final cycle of the current access
    logic waiting; // Software waits still running
    logic checking; // Ready detection on for this access
    logic hit; // Request falls on on-chip ROM

    // Counts software waits and stretches on ready
    emb_wait u_wait (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(start),
        .i_wait_states(i_req.wait_states),
        .i_ready(i_ready),
        .o_last(wait_last),
        .o_waiting(waiting),
        .o_checking(checking)
    );

    // ROM page decode for the incoming request
    assign hit = emb_rom_hit(cur.mode, i_req); // R10 R11

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.rom_hit = 1'b0;
        start = 1'b0;
        // Software write to the mode register wins over the reset choice
        if (i_mode_wr) begin
            next_cur.mode = i_mode_wdata; // R13
        end
        case (cur.fsm)
            EMB_IDLE: begin
                if (!i_hold_n) begin
                    // Give the bus away; nothing in flight
                    next_cur.fsm = EMB_HOLD; // R16
                    next_cur.release_ack = 1'b1; // R16
                end else if (i_req.valid && hit) begin
                    // Internal ROM fetch leaves the pins idle
                    next_cur.done = 1'b1;
                    next_cur.rom_hit = 1'b1;
                end else if (i_req.valid) begin
                    start = 1'b1;
                    next_cur.fsm = EMB_ACCESS;
                    next_cur.pins.addr = i_req.addr; // R2
                    // Exactly one select for the target space
                    next_cur.pins.data_space_sel_n = (i_req.space != EMB_SPACE_DATA); // R1 R17
                    next_cur.pins.program_space_sel_n = (i_req.space != EMB_SPACE_PROG); // R1 R17
                    next_cur.pins.io_space_sel_n = (i_req.space != EMB_SPACE_IO); // R1 R17
                    next_cur.pins.memory_strobe_n = (i_req.space == EMB_SPACE_IO); // R4
                    next_cur.pins.io_strobe_n = (i_req.space != EMB_SPACE_IO); // R15
                    next_cur.pins.read_not_write = !i_req.write; // R14
                end
            end
            EMB_ACCESS: begin
                // Pins stand until the waits and any ready stretch end
                if (wait_last) begin
                    next_cur.fsm = EMB_IDLE;
                    next_cur.pins = EMB_PINS_IDLE; // R1 R2 R4 R14 R15
                    next_cur.done = 1'b1;
                end
            end
            EMB_HOLD: begin
                // Take the bus back once the request drops
                if (i_hold_n) begin
                    next_cur.fsm = EMB_IDLE;
                    next_cur.release_ack = 1'b0; // R16
                end
            end
            default: begin
                next_cur.fsm = EMB_IDLE;
                next_cur.pins = EMB_PINS_IDLE;
            end
        endcase
        // Float the bus in hold and under emulation float
        next_cur.pins_oe_n = (next_cur.fsm == EMB_HOLD) || !i_emulation_float_n; // R3 R5 R6 R14
        next_cur.ack_oe_n = !i_emulation_float_n;
        next_cur.busy = (next_cur.fsm != EMB_IDLE);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cur.fsm <= EMB_IDLE;
            cur.pins <= EMB_PINS_IDLE;
            cur.pins_oe_n <= 1'b0;
            cur.release_ack <= 1'b0;
            cur.ack_oe_n <= 1'b0;
            cur.mode <= i_boot_map_select; // R10 R11 R12
            cur.done <= 1'b0;
            cur.rom_hit <= 1'b0;
            cur.busy <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_pins = cur.pins;
    assign o_pins_oe_n = cur.pins_oe_n;
    assign o_bus_release_ack = cur.release_ack;
    assign o_bus_release_ack_oe_n = cur.ack_oe_n;
    assign o_processor_mode = cur.mode;
    assign o_done = cur.done;
    assign o_rom_hit = cur.rom_hit;
    assign o_busy = cur.busy;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Helper signals
    logic [2:0] sels_n; // Select pins grouped
    assign sels_n = {cur.pins.data_space_sel_n, cur.pins.program_space_sel_n,
        cur.pins.io_space_sel_n};

    // Request taken to the external bus this cycle
    sequence ext_take_s;
        cur.fsm == EMB_IDLE && i_hold_n && i_req.valid && !hit;
    endsequence

    // Waits spent, ready detection on, device not ready
    sequence ready_low_s;
        cur.fsm == EMB_ACCESS && !waiting && checking && !i_ready;
    endsequence

    // Request for data or program space
    sequence mem_space_s;
        i_req.space == EMB_SPACE_DATA || i_req.space == EMB_SPACE_PROG;
    endsequence

    // Request for I/O space
    sequence io_space_s;
        i_req.space == EMB_SPACE_IO;
    endsequence

    // Outside master asks for the bus while idle
    sequence hold_take_s;
        cur.fsm == EMB_IDLE && !i_hold_n;
    endsequence

    // Never two spaces selected at once
    one_select_a: assert property ($onehot0(~sels_n)) // R17
        else $error("more than one space select low");

    // Selects rest high whenever no external access runs
    idle_high_a: assert property (cur.fsm != EMB_ACCESS |-> sels_n == 3'h7) // R1
        else $error("space select low outside an access");

    // A taken request shows its select and address on the next cycle
    select_addr_a: assert property (ext_take_s |=> // R2
        sels_n != 3'h7 && o_pins.addr == $past(i_req.addr))
        else $error("select or address wrong at access start");

    // Address holds still for the whole select-low interval
    addr_stable_a: assert property ( // R2
        cur.fsm == EMB_ACCESS && $past(cur.fsm) == EMB_ACCESS |-> $stable(o_pins.addr))
        else $error("address moved while select low");

    // Selects are already high in the completion cycle
    done_release_a: assert property (o_done |-> sels_n == 3'h7) // R2
        else $error("select still low when the access completed");

    // Hold floats every pin and raises the acknowledge
    hold_float_a: assert property ( // R3 R5 R16
        cur.fsm == EMB_HOLD |-> o_pins_oe_n && o_bus_release_ack)
        else $error("pins driven or no acknowledge in hold");

    // Emulation float releases the pins and the acknowledge a cycle later
    emu_float_a: assert property ( // R3 R6
        !i_emulation_float_n |=> o_pins_oe_n && o_bus_release_ack_oe_n)
        else $error("pins driven under emulation float");

    // Pins are driven again once neither hold nor emulation float applies
    emu_drive_a: assert property ( // R3 R5 R6
        i_emulation_float_n && i_hold_n && cur.fsm != EMB_HOLD |=> !o_pins_oe_n)
        else $error("pins left floating outside hold and emulation float");

    // Memory strobe only alongside a data or program select
    strobe_space_a: assert property ( // R4
        !o_pins.memory_strobe_n |-> !o_pins.data_space_sel_n || !o_pins.program_space_sel_n)
        else $error("memory strobe without memory select");

    // Data or program access drives the memory strobe low
    mem_strobe_a: assert property (ext_take_s ##0 mem_space_s |=> // R4
        !o_pins.memory_strobe_n && o_pins.io_strobe_n)
        else $error("memory strobe missing on a memory access");

    // I/O access uses the I/O strobe and leaves the memory strobe high
    io_access_a: assert property (ext_take_s ##0 io_space_s |=> // R15
        o_pins.memory_strobe_n && !o_pins.io_strobe_n && !o_pins.io_space_sel_n)
        else $error("wrong strobe on an I/O access");

    // I/O strobe follows the I/O select
    io_strobe_a: assert property (o_pins.io_strobe_n == o_pins.io_space_sel_n) // R15
        else $error("I/O strobe not matching I/O select");

    // Write level only inside an access
    write_only_a: assert property (!o_pins.read_not_write |-> cur.fsm == EMB_ACCESS) // R14
        else $error("write level outside an access");

    // A write request drives read-not-write low
    write_level_a: assert property (ext_take_s ##0 i_req.write |=> // R14
        !o_pins.read_not_write)
        else $error("read-not-write high during a write");

    // Ready low after the waits keeps the access open
    ready_stretch_a: assert property (ready_low_s |=> cur.fsm == EMB_ACCESS && !o_done) // R7
        else $error("access ended while ready low");

    // Without ready detection the access ends once the waits are spent
    ready_ignored_a: assert property ( // R8
        cur.fsm == EMB_ACCESS && !waiting && !checking |=> cur.fsm == EMB_IDLE && o_done)
        else $error("ready checked with under two waits");

    // One software wait: two select cycles whatever ready does
    short_wait_a: assert property (ext_take_s ##0 (i_req.wait_states == 3'h1) |=> // R8
        cur.fsm == EMB_ACCESS ##1 cur.fsm == EMB_ACCESS ##1 (cur.fsm == EMB_IDLE && o_done))
        else $error("single wait access length wrong");

    // Seven software waits: eight select cycles before ready may count
    long_wait_a: assert property (ext_take_s ##0 (i_req.wait_states == 3'h7) |=> // R9
        (cur.fsm == EMB_ACCESS) [*8])
        else $error("access ended inside its software waits");

    // Mode moves only on reset or a software write
    mode_hold_a: assert property ( // R12
        !$past(i_rst) && !$past(i_mode_wr) |-> $stable(cur.mode))
        else $error("mode changed without a software write");

    // A software write sets the mode on the next cycle
    mode_write_a: assert property ( // R13
        i_mode_wr |=> o_processor_mode == $past(i_mode_wdata))
        else $error("mode write not taken");

    // Microcomputer mode serves the ROM page internally
    rom_internal_a: assert property ( // R10
        cur.fsm == EMB_IDLE && i_hold_n && i_req.valid && hit |=>
        o_done && o_rom_hit && sels_n == 3'h7)
        else $error("ROM access went to the external bus");

    // Microprocessor mode never serves a request from on-chip ROM
    rom_out_a: assert property ( // R11
        cur.mode == EMB_MODE_MICROPROCESSOR && cur.fsm == EMB_IDLE && i_req.valid |=> !o_rom_hit)
        else $error("ROM decoded in microprocessor mode");

    // Hold taken from idle, acknowledged on the next cycle
    hold_enter_a: assert property (hold_take_s |=> // R16
        cur.fsm == EMB_HOLD && o_bus_release_ack && o_pins_oe_n)
        else $error("hold request not acknowledged");

    // Dropping the hold request takes the bus back
    hold_leave_a: assert property ( // R16
        cur.fsm == EMB_HOLD && i_hold_n |=> cur.fsm == EMB_IDLE && !o_bus_release_ack)
        else $error("bus not taken back after hold");

    // An access in flight finishes before the bus is given away
    access_first_a: assert property ( // R16
        cur.fsm == EMB_ACCESS |=> cur.fsm != EMB_HOLD)
        else $error("bus released in mid access");

endmodule // emb_ctl

`default_nettype wire

// >>> tb/emb_mem_model.sv
// External memory model: answers every access on the ready line.
// Assumes the bench gives the programmed waits and the extra stall cycles.
`default_nettype none

module emb_mem_model (
    input wire logic i_mclk,
    input wire emb_pkg::emb_pins_type i_pins,
    input wire logic i_pins_oe_n,
    input wire logic [emb_pkg::EMB_WS_W-1:0] i_waits,
    input wire logic [3:0] i_stall,
    output logic o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;

    int k = 0; // Cycles since a select went low
    // Any space selected and driven
    wire logic sel = !i_pins_oe_n && !(i_pins.data_space_sel_n &&
        i_pins.program_space_sel_n && i_pins.io_space_sel_n);

    // Not ready through the software waits and the stall; low when idle too
    always @(negedge i_mclk) begin
        if (sel) begin
            o_ready <= (k >= int'(i_waits) + int'(i_stall));
            k <= k + 1;
        end else begin
            o_ready <= 1'b0;
            k <= 0;
        end
    end
endmodule // emb_mem_model

`default_nettype wire

// >>> tb/emb_ctl_tb_top.sv
// Self-checking bench for the external memory bus control block.
// Assumes emb_pkg, emb_ctl and emb_mem_model are compiled before it.
`default_nettype none

module emb_ctl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;

    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    emb_req_type req = '0;
    logic ready;
    logic hold_n = 1'b1;
    logic emu_n = 1'b1;
    logic bms = 1'b0;
    logic mode_wr = 1'b0;
    logic mode_wdata = 1'b0;
    emb_pins_type pins;
    logic oe_n, ack, ack_oe_n, pmode, done, rom_hit, busy;
    logic [2:0] cfg_w = 3'h0;
    logic [3:0] cfg_stall = 4'h0;
    int n_mismatch = 0;
    int checks = 0;

    emb_ctl DUT (.i_mclk(mclk), .i_rst(rst), .i_req(req), .i_ready(ready),
        .i_hold_n(hold_n), .i_emulation_float_n(emu_n), .i_boot_map_select(bms),
        .i_mode_wr(mode_wr), .i_mode_wdata(mode_wdata), .o_pins(pins),
        .o_pins_oe_n(oe_n), .o_bus_release_ack(ack), .o_bus_release_ack_oe_n(ack_oe_n),
        .o_processor_mode(pmode), .o_done(done), .o_rom_hit(rom_hit), .o_busy(busy));
    emb_mem_model MEM (.i_mclk(mclk), .i_pins(pins), .i_pins_oe_n(oe_n),
        .i_waits(cfg_w), .i_stall(cfg_stall), .o_ready(ready));

    // Free-running machine clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Reset for ten cycles with the given map select level
    task automatic do_reset(input logic sel);
        bms = sel;
        rst = 1'b1;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        chk({pmode, pins[25:20], busy}, {sel, 6'h3f, 1'b0});
    endtask

    // One access; checks pins per selected cycle and the length of the access
    task automatic access(input logic [1:0] sp, input logic wr, input logic [19:0] a,
            input logic [2:0] w, input logic [3:0] st, input logic rom);
        int n;
        int exp_n;
        logic [5:0] exp_p;
        n = 0;
        exp_n = rom ? 0 : 1 + int'(w) + ((w >= EMB_READY_MIN_WS) ? int'(st) : 0);
        exp_p = {sp != EMB_SPACE_DATA, sp != EMB_SPACE_PROG, sp != EMB_SPACE_IO,
            sp == EMB_SPACE_IO, sp != EMB_SPACE_IO, !wr};
        cfg_w = w;
        cfg_stall = st;
        req = '{valid: 1'b1, space: sp, write: wr, addr: a, wait_states: w};
        @(negedge mclk);
        req.valid = 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) begin
            if (pins[25:23] !== 3'h7) begin
                n++;
                chk({busy, 1'b0, pins[25:20]}, {2'h2, exp_p});
                chk(8'(pins.addr == a), 8'h1);
            end
            @(negedge mclk);
        end
        if (done !== 1'b1) begin
            $display("[ERR] %0t access never completed", $time);
            n_mismatch++;
            test_done();
        end else begin
            chk({rom_hit, busy, pins[25:20]}, {rom, 7'h3f});
            chk(8'(n), 8'(exp_n));
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_map();
        bms = 1'b1;
        @(negedge mclk);
        chk(8'(pmode), 8'(EMB_MODE_MICROCOMPUTER));
        access(EMB_SPACE_PROG, 1'b0, 20'h3f123, 3'h2, 4'h0, 1'b1);
        access(EMB_SPACE_PROG, 1'b0, 20'h0e000, 3'h0, 4'h0, 1'b0);
        $display("Test map done");
    endtask

    task automatic t_ready();
        access(EMB_SPACE_DATA, 1'b0, 20'h01234, 3'h2, 4'h1, 1'b0);
        access(EMB_SPACE_DATA, 1'b1, 20'h0abcd, 3'h3, 4'h2, 1'b0);
        access(EMB_SPACE_PROG, 1'b0, 20'h8e000, 3'h7, 4'h0, 1'b0);
        access(EMB_SPACE_IO, 1'b1, 20'h00055, 3'h1, 4'h3, 1'b0);
        access(EMB_SPACE_IO, 1'b0, 20'h000aa, 3'h0, 4'h2, 1'b0);
        $display("Test ready done");
    endtask

    task automatic t_hold();
        hold_n = 1'b0;
        req = '{valid: 1'b1, space: EMB_SPACE_DATA, write: 1'b0, addr: 20'h1, wait_states: 3'h0};
        repeat (2) @(negedge mclk);
        chk(8'({oe_n, ack, ack_oe_n, busy}), 8'h0d);
        req.valid = 1'b0;
        hold_n = 1'b1;
        repeat (2) @(negedge mclk);
        chk(8'({oe_n, ack, busy}), 8'h0);
        $display("Test hold done");
    endtask

    task automatic t_float();
        emu_n = 1'b0;
        @(negedge mclk);
        chk(8'({oe_n, ack_oe_n}), 8'h3);
        emu_n = 1'b1;
        @(negedge mclk);
        chk(8'({oe_n, ack_oe_n}), 8'h0);
        $display("Test float done");
    endtask

    task automatic t_mode();
        mode_wr = 1'b1;
        mode_wdata = EMB_MODE_MICROPROCESSOR;
        @(negedge mclk);
        mode_wr = 1'b0;
        chk(8'(pmode), 8'(EMB_MODE_MICROPROCESSOR));
        access(EMB_SPACE_PROG, 1'b0, 20'h0f000, 3'h0, 4'h0, 1'b0);
        do_reset(1'b1);
        access(EMB_SPACE_PROG, 1'b0, 20'h0ffff, 3'h0, 4'h0, 1'b0);
        mode_wr = 1'b1;
        mode_wdata = EMB_MODE_MICROCOMPUTER;
        @(negedge mclk);
        mode_wr = 1'b0;
        access(EMB_SPACE_PROG, 1'b0, 20'h0ffff, 3'h0, 4'h0, 1'b1);
        $display("Test mode done");
    endtask

    // Main sequence
    initial begin
        @(negedge mclk);
        do_reset(1'b0);
        t_map();
        t_ready();
        t_hold();
        t_float();
        t_mode();
        test_done();
    end
endmodule // emb_ctl_tb_top

`default_nettype wire
